/* verilog/component_video_path.sv */
// component video datapath: matrix, downformatter, luma high-pass and level control
//
// Contract
// - the matrix takes 9-bit r, g, b and gives 9-bit y, cb, cr
// - y is weighted rgb; cb is 0.5772 of b-y, cr 0.7296 of r-y
// - the matrix has unity gain, full scale in gives full scale out
// - y-cb-cr input bypasses the matrix with equal latency
// - both colour difference streams are low-pass filtered before rate reduction
// - both colour difference samples of a slot belong to its first luma sample
// - cr is delayed one clock behind cb before the chroma multiplexer
// - select zero marks the first clock of a slot, which carries cb
// - the multiplexer output is registered, so the mux runs on opposite phase
// - luma high-pass built from the delay taps boosts 2 dB at 6.75 MHz
// - the high-pass has unity dc gain and saturates to 0..511
// - component_filter_enable in the register at 29h switches the high-pass
// - luma out is int(component_contrast/68 times (y-128)) plus component_brightness
// - chroma out is int(component_saturation/64 times (c-128)) plus 128
// - all level control results are clamped to 1..254
// - level settings reset to contrast 44h, brightness 80h, saturation 40h
`timescale 1ns/10ps
`include "cvp_defines.svh"
module component_video_path
    import cvp_pkg::*;
#(
    parameter int SAMPLE_W = 9
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire rgb_t in_rgb,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata_r,
    output video_out_t vid_out
);

    if (SAMPLE_W != 9) begin : g_bad_width
        $error("component_video_path: only 9-bit samples are supported");
    end

    // 9-bit saturation shared by the matrix and the luma high-pass
    function automatic logic [8:0] clip9(input logic signed [11:0] v);
        if (v < 12'sh000) begin
            return 9'h000;
        end else if (v > `CVP_MAX9) begin
            return 9'h1ff;
        end else begin
            return v[8:0];
        end
    endfunction

    function automatic logic clipped9(input logic signed [11:0] v);
        return (v < 12'sh000) || (v > `CVP_MAX9);
    endfunction

    // 1-2-1 anti-alias low-pass, unity dc gain
    function automatic logic [8:0] lp121(input logic [8:0] a, input logic [8:0] b, input logic [8:0] c);
        logic [10:0] s;
        s = 11'(a) + {1'b0, b, 1'b0} + 11'(c);
        return s[10:2];
    endfunction

    // register file
    logic [7:0] ctrl_r;
    logic [7:0] contrast_r;
    logic [7:0] brightness_r;
    logic [7:0] saturation_r;
    logic hp_clip_r;
    logic mtx_clip_r;
    logic hp_clip_evt;
    logic mtx_clip_evt;
    logic filt_en;
    logic bypass_en;

    assign filt_en = ctrl_r[`CVP_CTRL_FILT_BIT];
    assign bypass_en = ctrl_r[`CVP_CTRL_BYPASS_BIT];

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ctrl_r <= `CVP_CTRL_RST;
            contrast_r <= `CVP_CONTRAST_RST;
            brightness_r <= `CVP_BRIGHTNESS_RST;
            saturation_r <= `CVP_SATURATION_RST;
        end else if (reg_wr) begin
            if (reg_addr == `CVP_ADDR_CTRL) begin
                ctrl_r <= reg_wdata & 8'h03;
            end else if (reg_addr == `CVP_ADDR_CONTRAST) begin
                contrast_r <= reg_wdata;
            end else if (reg_addr == `CVP_ADDR_BRIGHTNESS) begin
                brightness_r <= reg_wdata;
            end else if (reg_addr == `CVP_ADDR_SATURATION) begin
                saturation_r <= reg_wdata;
            end
        end
    end

    // sticky clip flags, write one to clear, a new event wins over the clear
    logic stat_clr;
    assign stat_clr = reg_wr && reg_addr == `CVP_ADDR_STATUS;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            hp_clip_r <= 1'b0;
            mtx_clip_r <= 1'b0;
        end else begin
            hp_clip_r <= hp_clip_evt || (hp_clip_r && !(stat_clr && reg_wdata[`CVP_STAT_HP_CLIP_BIT]));
            mtx_clip_r <= mtx_clip_evt || (mtx_clip_r && !(stat_clr && reg_wdata[`CVP_STAT_MTX_CLIP_BIT]));
        end
    end

    logic [7:0] status_val;
    logic [7:0] rdata_nxt;

    always_comb begin
        status_val = 8'h00;
        status_val[`CVP_STAT_HP_CLIP_BIT] = hp_clip_r;
        status_val[`CVP_STAT_MTX_CLIP_BIT] = mtx_clip_r;
        status_val[`CVP_STAT_BYPASS_BIT] = bypass_en;
        if (!reg_rd) begin
            rdata_nxt = 8'h00;
        end else if (reg_addr == `CVP_ADDR_CTRL) begin
            rdata_nxt = ctrl_r;
        end else if (reg_addr == `CVP_ADDR_CONTRAST) begin
            rdata_nxt = contrast_r;
        end else if (reg_addr == `CVP_ADDR_BRIGHTNESS) begin
            rdata_nxt = brightness_r;
        end else if (reg_addr == `CVP_ADDR_SATURATION) begin
            rdata_nxt = saturation_r;
        end else if (reg_addr == `CVP_ADDR_STATUS) begin
            rdata_nxt = status_val;
        end else begin
            rdata_nxt = 8'h00;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            reg_rdata_r <= 8'h00;
        end else begin
            reg_rdata_r <= rdata_nxt;
        end
    end

    // matrix stage 1: luma from weighted rgb, b, r and g carried along
    rgb_t s1_r;
    logic [8:0] y1_r;
    logic byp1_r;
    logic [20:0] y_sum;

    always_comb begin
        y_sum = `CVP_Y_KR * 21'(in_rgb.r) + `CVP_Y_KG * 21'(in_rgb.g) + `CVP_Y_KB * 21'(in_rgb.b);
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s1_r <= '0;
            y1_r <= 9'h000;
            byp1_r <= 1'b0;
        end else begin
            s1_r <= in_rgb;
            y1_r <= y_sum[18:10];
            byp1_r <= bypass_en;
        end
    end

    // matrix stage 2: colour differences, or the matched bypass
    ycc_t yc2_r;
    logic signed [20:0] cb_prod;
    logic signed [20:0] cr_prod;
    logic signed [11:0] cb_val;
    logic signed [11:0] cr_val;

    always_comb begin
        cb_prod = `CVP_KCB * 21'($signed({1'b0, s1_r.b}) - $signed({1'b0, y1_r}));
        cr_prod = `CVP_KCR * 21'($signed({1'b0, s1_r.r}) - $signed({1'b0, y1_r}));
        cb_val = 12'(cb_prod >>> `CVP_COEF_FRAC) + `CVP_MID9;
        cr_val = 12'(cr_prod >>> `CVP_COEF_FRAC) + `CVP_MID9;
        mtx_clip_evt = !byp1_r && (clipped9(cb_val) || clipped9(cr_val));
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            yc2_r <= '0;
        end else if (byp1_r) begin
            yc2_r <= '{y: s1_r.g, cb: s1_r.b, cr: s1_r.r};
        end else begin
            yc2_r <= '{y: y1_r, cb: clip9(cb_val), cr: clip9(cr_val)};
        end
    end

    // anti-alias low-pass on both colour differences
    logic [8:0] cb_t1_r;
    logic [8:0] cb_t2_r;
    logic [8:0] cr_t1_r;
    logic [8:0] cr_t2_r;
    logic [8:0] cb_lp_r;
    logic [8:0] cr_lp_r;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cb_t1_r <= 9'h100;
            cb_t2_r <= 9'h100;
            cr_t1_r <= 9'h100;
            cr_t2_r <= 9'h100;
            cb_lp_r <= 9'h100;
            cr_lp_r <= 9'h100;
        end else begin
            cb_t1_r <= yc2_r.cb;
            cb_t2_r <= cb_t1_r;
            cr_t1_r <= yc2_r.cr;
            cr_t2_r <= cr_t1_r;
            cb_lp_r <= lp121(yc2_r.cb, cb_t1_r, cb_t2_r);
            cr_lp_r <= lp121(yc2_r.cr, cr_t1_r, cr_t2_r);
        end
    end

    // luma delay taps double as a small high-pass: y1 + (2*y1 - y0 - y2)/16
    logic [8:0] yt1_r;
    logic [8:0] yt2_r;
    logic [8:0] yhp_r;
    logic signed [11:0] hp_edge;
    logic signed [11:0] hp_val;

    always_comb begin
        hp_edge = $signed({2'b00, yt1_r, 1'b0}) - $signed({3'b000, yc2_r.y}) - $signed({3'b000, yt2_r});
        hp_val = $signed({3'b000, yt1_r}) + (hp_edge >>> `CVP_HP_SHIFT);
        hp_clip_evt = filt_en && clipped9(hp_val);
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            yt1_r <= 9'h000;
            yt2_r <= 9'h000;
            yhp_r <= 9'h000;
        end else begin
            yt1_r <= yc2_r.y;
            yt2_r <= yt1_r;
            yhp_r <= filt_en ? clip9(hp_val) : yt1_r;
        end
    end

    // chroma multiplexer, registered output
    logic phase_r;
    logic [8:0] cr_d_r;
    logic [8:0] chroma_mux_r;
    logic [8:0] luma_mux_r;
    logic mux_sel_r;
    logic out_sel_r;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            phase_r <= 1'b0;
            cr_d_r <= 9'h100;
            chroma_mux_r <= 9'h100;
            luma_mux_r <= 9'h000;
            mux_sel_r <= 1'b0;
            out_sel_r <= 1'b0;
        end else begin
            phase_r <= !phase_r;
            cr_d_r <= cr_lp_r;
            chroma_mux_r <= phase_r ? cb_lp_r : cr_d_r;
            luma_mux_r <= yhp_r;
            mux_sel_r <= !phase_r;
            out_sel_r <= mux_sel_r;
        end
    end

    // level control
    logic [7:0] luma_lvl_r;
    logic [7:0] chroma_lvl_r;

    level_scale #(
        .GAIN_DIV(`CVP_LUMA_DIV)
    ) u_luma_level (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .din(luma_mux_r[8:1]),
        .gain(contrast_r),
        .offset(brightness_r),
        .dout_r(luma_lvl_r)
    );

    level_scale #(
        .GAIN_DIV(`CVP_CHROMA_DIV)
    ) u_chroma_level (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .din(chroma_mux_r[8:1]),
        .gain(saturation_r),
        .offset(`CVP_MID8),
        .dout_r(chroma_lvl_r)
    );

    assign vid_out = '{luma: luma_lvl_r, chroma: chroma_lvl_r, mux_sel: out_sel_r};

    // checks
    logic [2:0] up_r;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            up_r <= 3'h0;
        end else begin
            up_r <= {up_r[1:0], 1'b1};
        end
    end

    default clocking cb_main @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_grey_in;
        up_r[2] && !bypass_en && in_rgb.r == in_rgb.g && in_rgb.g == in_rgb.b;
    endsequence

    sequence s_flat_luma;
        up_r[2] ##0 $stable(yc2_r.y) [*2];
    endsequence

    a_matrix_grey_unity: assert property (
        s_grey_in |-> ##2 (yc2_r.y == $past(in_rgb.r, 2) && yc2_r.cb == 9'h100 && yc2_r.cr == 9'h100))
        else $error("grey input not mapped to equal luma and mid chroma");
    a_bypass_same_latency: assert property (
        (up_r[2] && bypass_en) |-> ##2 yc2_r == '{y: $past(in_rgb.g, 2), cb: $past(in_rgb.b, 2), cr: $past(in_rgb.r, 2)})
        else $error("bypass latency does not match the matrix");
    a_cb_slot_start: assert property (
        (up_r[2] && !mux_sel_r) |-> (chroma_mux_r == $past(cb_lp_r) ##1 mux_sel_r))
        else $error("slot start does not carry cb");
    a_cr_same_slot: assert property (
        (up_r[2] && mux_sel_r) |-> chroma_mux_r == $past(cr_lp_r, 2))
        else $error("cr not taken from the slot's sample");
    a_hp_dc_unity: assert property (s_flat_luma |=> yhp_r == $past(yc2_r.y))
        else $error("high-pass changes a flat luma level");
    a_hp_disabled_pass: assert property (
        (up_r[2] && !filt_en) |=> yhp_r == $past(yc2_r.y, 2))
        else $error("disabled high-pass does not pass luma");
    a_hp_nyquist_boost: assert property (
        (filt_en && yt2_r == 9'h064 && yt1_r == 9'h190 && yc2_r.y == 9'h064) |=> yhp_r == 9'h1b5)
        else $error("high-pass boost at half rate is wrong");
    a_ctrl_write_steers: assert property (
        (reg_wr && reg_addr == `CVP_ADDR_CTRL) |=> filt_en == $past(reg_wdata[`CVP_CTRL_FILT_BIT]))
        else $error("filter enable not written");
    a_level_defaults: assert property (
        !$past(resetn) |-> (contrast_r == `CVP_CONTRAST_RST && brightness_r == `CVP_BRIGHTNESS_RST
        && saturation_r == `CVP_SATURATION_RST))
        else $error("level settings not at their defaults after reset");
    a_read_one_cycle: assert property (
        (reg_rd && reg_addr == `CVP_ADDR_CTRL) |=> (reg_rdata_r == ctrl_r ##1 (reg_rdata_r == 8'h00 || $past(reg_rd))))
        else $error("read data not presented for exactly one cycle");

endmodule // component_video_path

/* verilog/cvp_defines.svh */
// register map, reset values and arithmetic constants of the component video path
`ifndef CVP_DEFINES_SVH
`define CVP_DEFINES_SVH

`define CVP_ADDR_CTRL 8'h29
`define CVP_ADDR_CONTRAST 8'h2a
`define CVP_ADDR_BRIGHTNESS 8'h2b
`define CVP_ADDR_SATURATION 8'h2c
`define CVP_ADDR_STATUS 8'h2d

`define CVP_CTRL_FILT_BIT 0
`define CVP_CTRL_BYPASS_BIT 1
`define CVP_STAT_HP_CLIP_BIT 0
`define CVP_STAT_MTX_CLIP_BIT 1
`define CVP_STAT_BYPASS_BIT 2

`define CVP_CTRL_RST 8'h00
`define CVP_CONTRAST_RST 8'h44
`define CVP_BRIGHTNESS_RST 8'h80
`define CVP_SATURATION_RST 8'h40

`define CVP_Y_KR 21'sh132
`define CVP_Y_KG 21'sh259
`define CVP_Y_KB 21'sh075
`define CVP_KCB 21'sh24f
`define CVP_KCR 21'sh2eb
`define CVP_COEF_FRAC 10
`define CVP_MID9 12'sh100
`define CVP_MAX9 12'sh1ff
`define CVP_HP_SHIFT 4

`define CVP_MID8 8'h80
`define CVP_LEVEL_MIN 8'h01
`define CVP_LEVEL_MAX 8'hfe
`define CVP_LEVEL_MIN_S 20'sh00001
`define CVP_LEVEL_MAX_S 20'sh000fe
`define CVP_LUMA_DIV 68
`define CVP_CHROMA_DIV 64

`endif

/* verilog/cvp_pkg.sv */
// types carried through the component video path
package cvp_pkg;

    typedef struct packed {
        logic [8:0] r;
        logic [8:0] g;
        logic [8:0] b;
    } rgb_t;

    typedef struct packed {
        logic [8:0] y;
        logic [8:0] cb;
        logic [8:0] cr;
    } ycc_t;

    typedef struct packed {
        logic [7:0] luma;
        logic [7:0] chroma;
        logic mux_sel;
    } video_out_t;

endpackage

/* verilog/level_scale.sv */
// gain, offset and itu limiting of one 8-bit video stream
`timescale 1ns/10ps
`include "cvp_defines.svh"
module level_scale
    import cvp_pkg::*;
#(
    parameter int GAIN_DIV = `CVP_CHROMA_DIV
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [7:0] din,
    input wire logic [7:0] gain,
    input wire logic [7:0] offset,
    output logic [7:0] dout_r
);

    if (GAIN_DIV < 1 || GAIN_DIV > 255) begin : g_bad_div
        $error("level_scale: divisor out of range");
    end

    localparam logic signed [19:0] DIV_S = 20'(GAIN_DIV);

    function automatic logic [7:0] limit_itu(input logic signed [19:0] v);
        if (v < `CVP_LEVEL_MIN_S) begin
            return `CVP_LEVEL_MIN;
        end else if (v > `CVP_LEVEL_MAX_S) begin
            return `CVP_LEVEL_MAX;
        end else begin
            return v[7:0];
        end
    endfunction

    logic signed [9:0] diff;
    logic signed [19:0] prod;
    logic signed [19:0] quot;
    logic [7:0] dout_nxt;

    always_comb begin
        diff = $signed({2'b00, din}) - 10'sh080;
        prod = $signed({12'h000, gain}) * 20'(diff);
        quot = prod / DIV_S;
        dout_nxt = limit_itu(quot + $signed({12'h000, offset}));
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            dout_r <= `CVP_MID8;
        end else begin
            dout_r <= dout_nxt;
        end
    end

    default clocking cb_lvl @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_level_range_itu: assert property (dout_r >= `CVP_LEVEL_MIN && dout_r <= `CVP_LEVEL_MAX)
        else $error("level output outside 1..254");
    a_level_black_offset: assert property (
        ($past(resetn) && $past(din) == 8'h80) |-> dout_r == limit_itu($signed({12'h000, $past(offset)})))
        else $error("mid input does not give the offset");
    a_level_unit_gain: assert property (
        (GAIN_DIV == `CVP_CHROMA_DIV && $past(resetn) && $past(gain) == 8'h40 && $past(offset) == 8'h80)
        |-> dout_r == limit_itu($signed({12'h000, $past(din)})))
        else $error("nominal saturation is not unity");

endmodule // level_scale

/* tb/cvp_source.sv */
// front-end model: one sample per clock from the converter, steady or alternating
`timescale 1ns/10ps
module cvp_source
    import cvp_pkg::*;
(
    input wire logic sys_clk,
    input wire rgb_t base_val,
    input wire rgb_t alt_val,
    input wire logic alt_en,
    output rgb_t in_rgb
);
    logic phase_r;

    initial begin
        phase_r = 1'b0;
        in_rgb = '0;
    end

    // free-running sample stream, no handshake; alternation gives a half-rate pattern
    always @(posedge sys_clk) begin
        phase_r <= ~phase_r;
        in_rgb <= (alt_en && phase_r) ? alt_val : base_val;
    end
endmodule // cvp_source

/* tb/component_video_path_bench.sv */
// self-checking bench of the component video path
`timescale 1ns/10ps
`include "cvp_defines.svh"
module component_video_path_bench;
    import cvp_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] con;
        logic [7:0] bri;
        logic [7:0] sat;
        rgb_t src;
        logic [7:0] el;
        logic [7:0] ecb;
        logic [7:0] ecr;
    } row_t;

    // ctrl, contrast, brightness, saturation, {r,g,b} (bypass: r=cr g=y b=cb), luma, cb, cr
    localparam row_t ROWS [9] = '{
        '{8'h02, 8'h44, 8'h80, 8'h40, '{9'h100, 9'h100, 9'h100}, 8'h80, 8'h80, 8'h80},
        '{8'h02, 8'h44, 8'h80, 8'h40, '{9'h1fe, 9'h1fe, 9'h000}, 8'hfe, 8'h01, 8'hfe},
        '{8'h03, 8'h88, 8'h10, 8'h20, '{9'h150, 9'h0c8, 9'h0c8}, 8'h01, 8'h72, 8'h94},
        '{8'h02, 8'h22, 8'h40, 8'h60, '{9'h103, 9'h00b, 9'h0fb}, 8'h03, 8'h7c, 8'h81},
        '{8'h03, 8'hff, 8'hff, 8'hff, '{9'h0fc, 9'h102, 9'h104}, 8'hfe, 8'h87, 8'h79},
        '{8'h02, 8'h00, 8'h00, 8'h00, '{9'h1ff, 9'h1ff, 9'h000}, 8'h01, 8'h80, 8'h80},
        '{8'h00, 8'h44, 8'h80, 8'h40, '{9'h1ff, 9'h1ff, 9'h1ff}, 8'hfe, 8'h80, 8'h80},
        '{8'h00, 8'h44, 8'h80, 8'h40, '{9'h1ff, 9'h000, 9'h000}, 8'h4c, 8'h54, 8'hfe},
        '{8'h00, 8'h44, 8'h80, 8'h40, '{9'h000, 9'h000, 9'h1ff}, 8'h1d, 8'hfe, 8'h6a}
    };

    logic sys_clk;
    logic resetn;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata_r;
    rgb_t in_rgb;
    rgb_t base_val;
    rgb_t alt_val;
    logic alt_en;
    video_out_t vid_out;
    int n_fail;
    int n_checks;
    int n_rgb;
    int n_byp;

    cvp_source src (.sys_clk(sys_clk), .base_val(base_val), .alt_val(alt_val), .alt_en(alt_en), .in_rgb(in_rgb));

    component_video_path #(.SAMPLE_W(9)) dut (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .in_rgb(in_rgb),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata_r(reg_rdata_r),
        .vid_out(vid_out)
    );

    always #5 sys_clk = ~sys_clk;

    task automatic end_of_test();
        if (n_fail == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check8(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic check_int(input string nm, input int exp, input int got);
        n_checks++;
        if (got != exp) begin
            n_fail++;
            $display("mismatch %s expected %0d seen %0d", nm, exp, got);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check8("reg_rdata_r", exp, reg_rdata_r);
    endtask

    task automatic check_slot(input logic [7:0] el, input logic [7:0] ecb, input logic [7:0] ecr);
        int k;
        k = 0;
        settle(14);
        #1;
        while (vid_out.mux_sel !== 1'b0 && k < 3) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        check8("mux_sel first", 8'h00, {7'h00, vid_out.mux_sel});
        check8("luma", el, vid_out.luma);
        check8("chroma cb", ecb, vid_out.chroma);
        @(posedge sys_clk);
        #1;
        check8("mux_sel second", 8'h01, {7'h00, vid_out.mux_sel});
        check8("chroma cr", ecr, vid_out.chroma);
    endtask

    task automatic check_alt(input logic [7:0] hi, input logic [7:0] lo);
        logic [7:0] a;
        logic [7:0] b;
        settle(14);
        #1;
        a = vid_out.luma;
        @(posedge sys_clk);
        #1;
        b = vid_out.luma;
        check8("luma high", hi, (a > b) ? a : b);
        check8("luma low", lo, (a > b) ? b : a);
    endtask

    task automatic step_count(input logic [7:0] ctrl, output int n);
        reg_write(`CVP_ADDR_CTRL, ctrl);
        base_val <= '{9'h100, 9'h100, 9'h100};
        settle(14);
        base_val <= '{9'h1fe, 9'h1fe, 9'h1fe};
        n = 0;
        @(posedge sys_clk);
        #1;
        while (vid_out.luma !== 8'hfe && n < 30) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check8("step seen", 8'h01, {7'h00, n < 30});
    endtask

    initial begin
        #500000;
        n_fail++;
        end_of_test();
    end

    initial begin
        sys_clk = 1'b0;
        resetn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        base_val = '0;
        alt_val = '0;
        alt_en = 1'b0;
        n_fail = 0;
        n_checks = 0;
        settle(3);
        #1;
        check8("reset luma", 8'h80, vid_out.luma);
        check8("reset chroma", 8'h80, vid_out.chroma);
        check8("reset rdata", 8'h00, reg_rdata_r);
        @(posedge sys_clk);
        resetn <= 1'b1;
        reg_read(`CVP_ADDR_CONTRAST, `CVP_CONTRAST_RST);
        reg_read(`CVP_ADDR_BRIGHTNESS, `CVP_BRIGHTNESS_RST);
        reg_read(`CVP_ADDR_SATURATION, `CVP_SATURATION_RST);
        reg_read(`CVP_ADDR_CTRL, 8'h00);
        reg_read(8'h30, 8'h00);
        reg_write(`CVP_ADDR_CTRL, 8'hff);
        reg_read(`CVP_ADDR_CTRL, 8'h03);
        for (int i = 0; i < 9; i++) begin
            reg_write(`CVP_ADDR_CTRL, ROWS[i].ctrl);
            reg_write(`CVP_ADDR_CONTRAST, ROWS[i].con);
            reg_write(`CVP_ADDR_BRIGHTNESS, ROWS[i].bri);
            reg_write(`CVP_ADDR_SATURATION, ROWS[i].sat);
            base_val <= ROWS[i].src;
            check_slot(ROWS[i].el, ROWS[i].ecb, ROWS[i].ecr);
        end
        // half-rate luma pattern 400/100: boosted edges with the filter on, plain with it off
        reg_write(`CVP_ADDR_CONTRAST, 8'h44);
        reg_write(`CVP_ADDR_BRIGHTNESS, 8'h80);
        reg_write(`CVP_ADDR_SATURATION, 8'h40);
        reg_write(`CVP_ADDR_CTRL, 8'h03);
        base_val <= '{9'h100, 9'h190, 9'h100};
        alt_val <= '{9'h100, 9'h064, 9'h100};
        alt_en <= 1'b1;
        check_alt(8'hda, 8'h1f);
        reg_write(`CVP_ADDR_CTRL, 8'h02);
        check_alt(8'hc8, 8'h32);
        // full-swing pattern drives the high-pass into both limits
        reg_write(`CVP_ADDR_CTRL, 8'h03);
        base_val <= '{9'h100, 9'h1ff, 9'h100};
        alt_val <= '{9'h100, 9'h000, 9'h100};
        check_alt(8'hfe, 8'h01);
        reg_read(`CVP_ADDR_STATUS, 8'h07);
        settle(1);
        alt_en <= 1'b0;
        // matrix and bypass must show the same latency
        step_count(8'h00, n_rgb);
        step_count(8'h02, n_byp);
        check_int("bypass latency", n_rgb, n_byp);
        // sticky matrix clip flag and its clear
        reg_write(`CVP_ADDR_CTRL, 8'h00);
        base_val <= '{9'h100, 9'h100, 9'h100};
        settle(14);
        reg_write(`CVP_ADDR_STATUS, 8'h03);
        reg_read(`CVP_ADDR_STATUS, 8'h00);
        settle(1);
        base_val <= '{9'h1ff, 9'h000, 9'h000};
        settle(14);
        base_val <= '{9'h100, 9'h100, 9'h100};
        settle(14);
        reg_read(`CVP_ADDR_STATUS, 8'h02);
        reg_write(`CVP_ADDR_STATUS, 8'h02);
        reg_read(`CVP_ADDR_STATUS, 8'h00);
        // second reset in mid-run restores the contrast default
        reg_write(`CVP_ADDR_CONTRAST, 8'h11);
        @(posedge sys_clk);
        resetn <= 1'b0;
        settle(2);
        resetn <= 1'b1;
        reg_read(`CVP_ADDR_CONTRAST, `CVP_CONTRAST_RST);
        end_of_test();
    end
endmodule // component_video_path_bench
